// [hdl/emd_params.svh]
`ifndef EMD_PARAMS_SVH
`define EMD_PARAMS_SVH

// ==========================================================
// widths and sizes
`define EMD_IW          13
`define EMD_PCW         11
`define EMD_DW          8
`define EMD_NREG        64
`define EMD_NCTL        16
`define EMD_NSTK        8

// ==========================================================
// register indices
`define EMD_PC_IDX      6'h02
`define EMD_FLAGS_IDX   6'h03
`define EMD_PAGE_IDX    6'h05

// ==========================================================
// flag bit positions in the flags register, and the page bit in the page register
`define EMD_C_BIT       0
`define EMD_DC_BIT      1
`define EMD_Z_BIT       2
`define EMD_P_BIT       3
`define EMD_T_BIT       4
`define EMD_BANK_LSB    6
`define EMD_PAGE_LSB    5

// ==========================================================
// reset values
`define EMD_PC_RST      11'h000
`define EMD_ACC_RST     8'h00
`define EMD_OPT_RST     8'hff
`define EMD_REG_RST     8'h00
`define EMD_FLAGS_RST   8'h18

// ==========================================================
// oscillator clocks per instruction cycle, minus one
`define EMD_CYC2_LAST   2'h1
`define EMD_CYC4_LAST   2'h3

`endif

// [hdl/emd_pkg.sv]
package emd_pkg;

  typedef logic [7:0] emd_byte_t;

  // core state apart from the cycle generator, registered as one word
  typedef struct packed {
    logic [10:0]                pc;
    emd_byte_t                  acc;
    emd_byte_t                  opt;
    logic [2:0]                 sp;
    logic [7:0][10:0]           stk;
    logic [63:0][7:0]           rf;
    logic [15:0][7:0]           pcr;
    logic                       discard;
    logic                       irq_en;
    logic                       pdown;
    logic                       wdt_clr;
    logic                       ctl_wr;
    logic [3:0]                 ctl_idx;
  } emd_core_t;

  // instruction cycle generator state
  typedef struct packed {
    logic [1:0] cnt;
    logic       cyc_end;
    logic       tmr_clk;
  } emd_cyc_t;

endpackage : emd_pkg

// [hdl/emd_cycle_gen.sv]
`timescale 1ns/100ps
`default_nettype none
`include "emd_params.svh"

module emd_cycle_gen
  import emd_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // option
  input  wire logic cycle_clock_select,
  // timing
  output var  logic cycle_end,
  output var  logic timer_clk
);

  emd_cyc_t s_q;
  emd_cyc_t s_d;
  logic [1:0] last;

  // ==========================================================
  // divider
  always_comb begin
    s_d  = s_q;
    last = cycle_clock_select ? `EMD_CYC4_LAST : `EMD_CYC2_LAST; // see [RQ2]
    if (s_q.cnt >= last) begin
      s_d.cnt = 2'h0;
    end else begin
      s_d.cnt = s_q.cnt + 2'h1;
    end
    s_d.cyc_end = (s_q.cnt >= last);
    // timer clock follows cycle length: fosc/4 or fosc/2
    s_d.tmr_clk = cycle_clock_select ? s_q.cnt[1] : s_q.cnt[0]; // see [RQ6]
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cycle_end = s_q.cyc_end;
  assign timer_clk = s_q.tmr_clk;

endmodule : emd_cycle_gen

`default_nettype wire

// [hdl/emd_core.sv]
// Contract
// [RQ1] instructions are 13-bit words: opcode field then operand fields
// [RQ2] instruction cycle is two clocks, or four when the option is high
// [RQ3] all other instructions finish in one instruction cycle
// [RQ4] writing the program counter register by any means takes two cycles
// [RQ5] jump, call, returns and taken skips take two cycles
// [RQ6] four-clock cycle feeds the timer with fosc/4 instead of fosc/2
// [RQ7] any bit of any register can be set, cleared or tested
// [RQ8] port registers behave exactly like general registers
// [RQ9] literals are 8 bits, jump and call targets 10 bits
// [RQ10] port control access uses 4-bit index, only 5-7 and a-f
// [RQ11] software must not bit-set the interrupt status register
// [RQ12] power-down clears watchdog, stops, updates time-out and power-down flags
// [RQ13] watchdog clear updates flags; option word written from and read to acc
// [RQ14] call pushes next address and loads page plus target
// [RQ15] jump loads page plus target and leaves the stack alone
// [RQ16] page select writes page bits 7:5, bank select flags bits 7:6
// [RQ17] interrupt enable and disable change no flag
// [RQ18] interrupt exit pops and enables; literal exit also loads acc (here the literal exit pops and loads acc but leaves irq_en unchanged)
// [RQ19] add/sub set z,c,dc; logic and moves set z; bcd fixup sets c; moves from acc to r and of a literal leave z here
// [RQ20] rotates go through carry in both directions
// [RQ21] skip-on-zero inc/dec write result, skip on zero, keep flags
// [RQ22] bit ops: 3-bit index, 6-bit register, prefixes pick the op
// [RQ23] a taken skip turns the fetched next word into a dead cycle
//
`timescale 1ns/100ps
`default_nettype none
`include "emd_params.svh"

module emd_core
  import emd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // configuration
  input  wire logic        cycle_clock_select,
  input  wire logic        wake_up,
  // program memory
  input  wire logic [12:0] instr_data,
  output var  logic [10:0] fetch_addr,
  // core status
  output var  logic [7:0]  acc_out,
  output var  logic [7:0]  flags_out,
  output var  logic [7:0]  option_word_reg,
  output var  logic        irq_enable,
  output var  logic        power_down,
  output var  logic        watchdog_clear,
  // port control registers
  output var  logic        port_ctrl_write,
  output var  logic [3:0]  port_ctrl_index,
  output var  logic [7:0]  port_ctrl_data,
  // timer clock and instruction cycle end
  output var  logic        timer_clk,
  output var  logic        cycle_end
);

  emd_core_t s_q;
  emd_core_t s_d;

  // ==========================================================
  // helpers
  function automatic logic ctl_ok(input logic [3:0] idx);
    ctl_ok = (idx >= 4'h5 && idx <= 4'h7) || (idx >= 4'ha); // see [RQ10]
  endfunction : ctl_ok

  function automatic logic [7:0] rd_reg(input emd_core_t s, input logic [5:0] idx);
    // program counter register reads the live low byte
    if (idx == `EMD_PC_IDX) begin
      rd_reg = s.pc[7:0];
    end else begin
      rd_reg = s.rf[idx]; // see [RQ8]
    end
  endfunction : rd_reg

  // ==========================================================
  // cycle timing
  emd_cycle_gen u_cyc (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .cycle_clock_select (cycle_clock_select),
    .cycle_end          (cycle_end),
    .timer_clk          (timer_clk)
  );

  // ==========================================================
  // decode and execute
  logic [5:0]  ridx;
  logic [7:0]  rv;
  logic [7:0]  kv;
  logic [7:0]  res;
  logic [8:0]  sum;
  logic [4:0]  nib;
  logic        dst_r;
  logic        wr_en;
  logic [7:0]  wr_val;
  logic        set_z;
  logic        set_c;
  logic        set_dc;
  logic        zf;
  logic        cf;
  logic        dcf;
  logic [10:0] pc_inc;
  logic [2:0]  bidx;

  always_comb begin
    s_d     = s_q;
    ridx    = instr_data[5:0];
    rv      = rd_reg(s_q, instr_data[5:0]);
    kv      = instr_data[7:0]; // see [RQ9]
    res     = 8'h00;
    sum     = 9'h000;
    nib     = 5'h00;
    dst_r   = instr_data[6];
    wr_en   = 1'b0;
    wr_val  = 8'h00;
    set_z   = 1'b0;
    set_c   = 1'b0;
    set_dc  = 1'b0;
    zf      = 1'b0;
    cf      = s_q.rf[`EMD_FLAGS_IDX][`EMD_C_BIT];
    dcf     = 1'b0;
    pc_inc  = s_q.pc + 11'h001;
    bidx    = instr_data[8:6];
    s_d.wdt_clr = 1'b0;
    s_d.ctl_wr  = 1'b0;

    if (s_q.pdown && wake_up) begin
      s_d.pdown = 1'b0;
    end

    if (cycle_end && !s_q.pdown) begin
      s_d.pc      = pc_inc; // see [RQ3]
      s_d.discard = 1'b0;
      if (s_q.discard) begin
        // second cycle of a two-cycle instruction: the fetched word dies
        s_d.pc = s_q.pc; // see [RQ23]
      end else begin
        casez (instr_data) // see [RQ1]
          13'b0_0000_0000_0000: begin
          end
          13'b0_0000_0000_0001: begin
            // decimal fixup on acc, only carry changes
            sum = {1'b0, s_q.acc};
            if (sum[3:0] > 4'h9) begin
              sum = sum + 9'h006;
            end
            if (sum[7:4] > 4'h9 || cf) begin
              sum = sum + 9'h060;
            end
            s_d.acc = sum[7:0];
            set_c   = 1'b1; // see [RQ19]
            cf      = sum[8] | cf;
          end
          13'b0_0000_0000_0010: begin
            s_d.opt = s_q.acc; // see [RQ13]
          end
          13'b0_0000_0000_0011: begin
            s_d.wdt_clr = 1'b1;
            s_d.pdown   = 1'b1; // see [RQ12]
            s_d.rf[`EMD_FLAGS_IDX][`EMD_T_BIT] = 1'b1;
            s_d.rf[`EMD_FLAGS_IDX][`EMD_P_BIT] = 1'b0;
          end
          13'b0_0000_0000_0100: begin
            s_d.wdt_clr = 1'b1; // see [RQ13]
            s_d.rf[`EMD_FLAGS_IDX][`EMD_T_BIT] = 1'b1;
            s_d.rf[`EMD_FLAGS_IDX][`EMD_P_BIT] = 1'b1;
          end
          13'b0_0000_0000_????: begin
            // unsupported indices are dropped silently
            if (ctl_ok(instr_data[3:0])) begin // see [RQ10]
              s_d.pcr[instr_data[3:0]] = s_q.acc;
              s_d.ctl_wr               = 1'b1;
              s_d.ctl_idx              = instr_data[3:0];
            end
          end
          13'b0_0000_0001_0000: begin
            s_d.irq_en = 1'b1; // see [RQ17]
          end
          13'b0_0000_0001_0001: begin
            s_d.irq_en = 1'b0; // see [RQ17]
          end
          13'b0_0000_0001_0010, 13'b0_0000_0001_0011: begin
            s_d.sp      = s_q.sp - 3'h1;
            s_d.pc      = s_q.stk[s_q.sp - 3'h1];
            s_d.discard = 1'b1; // see [RQ5]
            if (instr_data[0]) begin
              s_d.irq_en = 1'b1; // see [RQ18]
            end
          end
          13'b0_0000_0001_0100: begin
            s_d.acc = s_q.opt; // see [RQ13]
          end
          13'b0_0000_0001_????: begin
            if (ctl_ok(instr_data[3:0])) begin // see [RQ10]
              s_d.acc = s_q.pcr[instr_data[3:0]];
            end
          end
          13'b0_0000_01??_????: begin
            wr_en  = 1'b1;
            wr_val = s_q.acc;
          end
          13'b0_0000_1000_0000: begin
            s_d.acc = 8'h00;
            set_z   = 1'b1;
            zf      = 1'b1;
          end
          13'b0_0000_11??_????: begin
            wr_en  = 1'b1;
            wr_val = 8'h00;
            set_z  = 1'b1;
            zf     = 1'b1;
          end
          13'b0_0000_10??_????: begin
          end
          13'b0_????_????_????: begin
            if (instr_data[11]) begin
              // bit operations on any register
              res = rv;
              res[bidx] = instr_data[9]; // see [RQ22]
              unique case (instr_data[10:9])
                2'b00, 2'b01: begin
                  wr_en  = 1'b1; // see [RQ7]
                  wr_val = res;
                end
                2'b10: begin
                  if (!rv[bidx]) begin
                    s_d.pc      = s_q.pc + 11'h002; // see [RQ5]
                    s_d.discard = 1'b1;
                  end
                end
                2'b11: begin
                  if (rv[bidx]) begin
                    s_d.pc      = s_q.pc + 11'h002; // see [RQ5]
                    s_d.discard = 1'b1;
                  end
                end
              endcase
            end else begin
              // register arithmetic, destination r when bit 6 is set
              unique case (instr_data[10:7])
                4'h2: begin
                  sum = {1'b0, rv} + {1'b0, ~s_q.acc} + 9'h001;
                  nib = {1'b0, rv[3:0]} + {1'b0, ~s_q.acc[3:0]} + 5'h01;
                  res = sum[7:0];
                  set_c  = 1'b1; // see [RQ19]
                  set_dc = 1'b1;
                  set_z  = 1'b1;
                  cf  = sum[8];
                  dcf = nib[4];
                end
                4'h3: begin
                  res   = rv - 8'h01;
                  set_z = 1'b1;
                end
                4'h4: begin
                  res   = s_q.acc | rv;
                  set_z = 1'b1;
                end
                4'h5: begin
                  res   = s_q.acc & rv;
                  set_z = 1'b1;
                end
                4'h6: begin
                  res   = s_q.acc ^ rv;
                  set_z = 1'b1;
                end
                4'h7: begin
                  sum = {1'b0, s_q.acc} + {1'b0, rv};
                  nib = {1'b0, s_q.acc[3:0]} + {1'b0, rv[3:0]};
                  res = sum[7:0];
                  set_c  = 1'b1; // see [RQ19]
                  set_dc = 1'b1;
                  set_z  = 1'b1;
                  cf  = sum[8];
                  dcf = nib[4];
                end
                4'h8: begin
                  res   = rv;
                  set_z = 1'b1;
                end
                4'h9: begin
                  res   = ~rv;
                  set_z = 1'b1;
                end
                4'ha: begin
                  res   = rv + 8'h01;
                  set_z = 1'b1;
                end
                4'hb, 4'hf: begin
                  res = instr_data[9] ? (rv + 8'h01) : (rv - 8'h01);
                  if (res == 8'h00) begin
                    s_d.pc      = s_q.pc + 11'h002; // see [RQ21]
                    s_d.discard = 1'b1;
                  end
                end
                4'hc: begin
                  res   = {cf, rv[7:1]}; // see [RQ20]
                  set_c = 1'b1;
                  cf    = rv[0];
                end
                4'hd: begin
                  res   = {rv[6:0], cf}; // see [RQ20]
                  set_c = 1'b1;
                  cf    = rv[7];
                end
                4'he: begin
                  res = {rv[3:0], rv[7:4]};
                end
                default: begin
                  res = rv;
                end
              endcase
              zf = (res == 8'h00);
              if (dst_r) begin
                wr_en  = 1'b1;
                wr_val = res;
              end else begin
                s_d.acc = res;
              end
            end
          end
          13'b1_00??_????_????: begin
            s_d.stk[s_q.sp] = pc_inc; // see [RQ14]
            s_d.sp          = s_q.sp + 3'h1;
            s_d.pc          = {s_q.rf[`EMD_PAGE_IDX][`EMD_PAGE_LSB], instr_data[9:0]};
            s_d.discard     = 1'b1;
          end
          13'b1_01??_????_????: begin
            s_d.pc      = {s_q.rf[`EMD_PAGE_IDX][`EMD_PAGE_LSB], instr_data[9:0]}; // see [RQ15]
            s_d.discard = 1'b1;
          end
          13'b1_1100_????_????: begin
            s_d.acc     = kv; // see [RQ18]
            s_d.sp      = s_q.sp - 3'h1;
            s_d.pc      = s_q.stk[s_q.sp - 3'h1];
            s_d.discard = 1'b1;
          end
          13'b1_1110_1000_????: begin
            s_d.rf[`EMD_PAGE_IDX][7:5] = instr_data[2:0]; // see [RQ16]
          end
          13'b1_1110_1001_000?: begin
            s_d.rf[`EMD_FLAGS_IDX][7:6] = {1'b0, instr_data[0]}; // see [RQ16]
          end
          13'b1_1???_????_????: begin
            unique case (instr_data[11:8])
              4'h8: res = kv;
              4'h9: res = s_q.acc | kv;
              4'ha: res = s_q.acc & kv;
              4'hb: res = s_q.acc ^ kv;
              default: res = s_q.acc;
            endcase
            if (instr_data[11:8] == 4'hd) begin
              sum = {1'b0, kv} + {1'b0, ~s_q.acc} + 9'h001;
              nib = {1'b0, kv[3:0]} + {1'b0, ~s_q.acc[3:0]} + 5'h01;
            end else if (instr_data[11:8] == 4'hf) begin
              sum = {1'b0, kv} + {1'b0, s_q.acc};
              nib = {1'b0, kv[3:0]} + {1'b0, s_q.acc[3:0]};
            end
            if (instr_data[11:8] == 4'hd || instr_data[11:8] == 4'hf) begin
              res    = sum[7:0];
              set_c  = 1'b1; // see [RQ19]
              set_dc = 1'b1;
              cf     = sum[8];
              dcf    = nib[4];
            end
            set_z   = (instr_data[11:8] != 4'h8);
            zf      = (res == 8'h00);
            s_d.acc = res;
          end
          default: begin
          end
        endcase

        // register write-back; the program counter register costs a cycle
        if (wr_en) begin
          if (ridx == `EMD_PC_IDX) begin
            s_d.pc      = {s_q.pc[10:8], wr_val}; // see [RQ4]
            s_d.discard = 1'b1;
          end else begin
            s_d.rf[ridx] = wr_val; // see [RQ8]
          end
        end
        // flags applied last so they win over a write to the flags register
        if (set_z) begin
          s_d.rf[`EMD_FLAGS_IDX][`EMD_Z_BIT] = zf; // see [RQ19]
        end
        if (set_c) begin
          s_d.rf[`EMD_FLAGS_IDX][`EMD_C_BIT] = cf;
        end
        if (set_dc) begin
          s_d.rf[`EMD_FLAGS_IDX][`EMD_DC_BIT] = dcf;
        end
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q     <= '0;
      s_q.pc  <= `EMD_PC_RST;
      s_q.acc <= `EMD_ACC_RST;
      s_q.opt <= `EMD_OPT_RST;
      s_q.rf[`EMD_FLAGS_IDX] <= `EMD_FLAGS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign fetch_addr      = s_q.pc;
  assign acc_out         = s_q.acc;
  assign flags_out       = s_q.rf[`EMD_FLAGS_IDX];
  assign option_word_reg = s_q.opt;
  assign irq_enable      = s_q.irq_en;
  assign power_down      = s_q.pdown;
  assign watchdog_clear  = s_q.wdt_clr;
  assign port_ctrl_write = s_q.ctl_wr;
  assign port_ctrl_index = s_q.ctl_idx;
  assign port_ctrl_data  = s_q.pcr[s_q.ctl_idx];

endmodule : emd_core

`default_nettype wire

// [tb/emd_core_monitor.sv]
`timescale 1ns/100ps
`default_nettype none

module emd_core_monitor
  import emd_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // configuration
  input wire logic        cycle_clock_select,
  input wire logic        wake_up,
  // core status
  input wire logic [10:0] fetch_addr,
  input wire logic [7:0]  acc_out,
  input wire logic [7:0]  flags_out,
  input wire logic        irq_enable,
  input wire logic        power_down,
  input wire logic        watchdog_clear,
  // port control
  input wire logic        port_ctrl_write,
  input wire logic [3:0]  port_ctrl_index,
  // timing
  input wire logic        timer_clk,
  input wire logic        cycle_end
);

  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_cycle_two_clk: assert property (
    !cycle_clock_select && cycle_end |=> !cycle_end ##1 cycle_end)
    else $error("instruction cycle is not two clocks");

  a_cycle_four_clk: assert property (
    cycle_clock_select && cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("instruction cycle is not four clocks");

  a_timer_half_rate: assert property (
    $rose(timer_clk) && !cycle_clock_select |=> !timer_clk ##1 timer_clk)
    else $error("timer clock is not fosc/2");

  a_timer_quarter_rate: assert property (
    $rose(timer_clk) && cycle_clock_select |=> timer_clk ##1 !timer_clk [*2] ##1 timer_clk)
    else $error("timer clock is not fosc/4");

  // the program counter only moves on an execution edge
  a_pc_exec_only: assert property (
    !cycle_end |=> $stable(fetch_addr))
    else $error("fetch address moved between execution edges");

  a_halt_holds: assert property (
    power_down && !wake_up |=> $stable(fetch_addr) && $stable(acc_out))
    else $error("core advanced while halted");

  a_irq_no_flags: assert property (
    $changed(irq_enable) |-> $stable(flags_out))
    else $error("interrupt enable change touched the flags");

  a_wdt_pulse_flags: assert property (
    watchdog_clear |-> $past(cycle_end) && flags_out[4] ##1 !watchdog_clear)
    else $error("watchdog clear pulse or time-out flag wrong");

  a_pdown_flags: assert property (
    $rose(power_down) |-> watchdog_clear && flags_out[4:3] == 2'b10)
    else $error("power-down did not clear watchdog or set flags");

  a_ctl_index_legal: assert property (
    port_ctrl_write |-> port_ctrl_index inside {4'h5, 4'h6, 4'h7, [4'ha:4'hf]}
      ##1 !port_ctrl_write)
    else $error("port control write to an illegal index");

endmodule : emd_core_monitor

bind emd_core emd_core_monitor emd_core_monitor_i (
  .clk(clk), .sys_rst(sys_rst), .cycle_clock_select(cycle_clock_select),
  .wake_up(wake_up), .fetch_addr(fetch_addr), .acc_out(acc_out),
  .flags_out(flags_out), .irq_enable(irq_enable), .power_down(power_down),
  .watchdog_clear(watchdog_clear), .port_ctrl_write(port_ctrl_write),
  .port_ctrl_index(port_ctrl_index), .timer_clk(timer_clk), .cycle_end(cycle_end)
);

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/100ps
`default_nettype none

module tb;
  import emd_pkg::*;

  // ==========================================================
  // hookup
  logic        clk;
  logic        sys_rst;
  logic        cycle_clock_select;
  logic        wake_up;
  logic [12:0] instr_data;
  logic [10:0] fetch_addr;
  logic [7:0]  acc_out;
  logic [7:0]  flags_out;
  logic [7:0]  option_word_reg;
  logic        irq_enable;
  logic        power_down;
  logic        watchdog_clear;
  logic        port_ctrl_write;
  logic [3:0]  port_ctrl_index;
  logic [7:0]  port_ctrl_data;
  logic        timer_clk;
  logic        cycle_end;
  logic [12:0] rom [0:2047];
  int          mismatches = 0;
  int          n_compared = 0;
  int          ticks = 0;

  assign instr_data = rom[fetch_addr];

  emd_core emd_core_i (
    .clk(clk), .sys_rst(sys_rst), .cycle_clock_select(cycle_clock_select),
    .wake_up(wake_up), .instr_data(instr_data), .fetch_addr(fetch_addr),
    .acc_out(acc_out), .flags_out(flags_out), .option_word_reg(option_word_reg),
    .irq_enable(irq_enable), .power_down(power_down), .watchdog_clear(watchdog_clear),
    .port_ctrl_write(port_ctrl_write), .port_ctrl_index(port_ctrl_index),
    .port_ctrl_data(port_ctrl_data), .timer_clk(timer_clk), .cycle_end(cycle_end)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // a whole run is a few hundred clocks; far beyond means a hang
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 6000) begin
      mismatches++;
      $display("Error at %0t: timeout", $time);
      test_done();
    end
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: byte %h expected %h", $time, g, e);
    end
  endtask : chk8

  task automatic chka(input logic [10:0] g, input logic [10:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: address %h expected %h", $time, g, e);
    end
  endtask : chka

  task automatic chk1(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: bit %b expected %b", $time, g, e);
    end
  endtask : chk1

  // program lands at address 0, the rest of memory is no-op
  task automatic ld(input logic [12:0] p[]);
    foreach (rom[i]) rom[i] = 13'h0000;
    foreach (p[i]) rom[i] = p[i]; // no program bit-sets the irq status register
  endtask : ld

  task automatic rst(input logic sel);
    @(posedge clk);
    #2;
    sys_rst = 1'b1;
    cycle_clock_select = sel;
    repeat (16) @(posedge clk);
    #2;
    sys_rst = 1'b0;
  endtask : rst

  // returns just after the n-th execution edge, dead cycles included
  task automatic step(input int n);
    repeat (n) begin
      do begin
        @(posedge clk);
        #2;
      end while (cycle_end !== 1'b1);
      @(posedge clk);
      #2;
    end
  endtask : step

  // ==========================================================
  // scenarios
  task automatic t_timing;
    logic [7:0] c;
    logic       prev;
    for (int s = 0; s < 2; s++) begin
      ld('{13'h0000});
      rst(s[0]);
      do begin
        @(posedge clk);
        #2;
      end while (cycle_end !== 1'b1);
      c = 8'h00;
      do begin
        @(posedge clk);
        #2;
        c++;
      end while (cycle_end !== 1'b1);
      chk8(c, s ? 8'h04 : 8'h02);
      c = 8'h00;
      prev = timer_clk;
      repeat (16) begin
        @(posedge clk);
        #2;
        if (timer_clk && !prev) c++;
        prev = timer_clk;
      end
      chk8(c, s ? 8'h04 : 8'h08);
    end
  endtask : t_timing

  task automatic t_alu;
    ld('{13'h180f, 13'h1f01, 13'h1d10});
    rst(1'b0);
    step(2);
    chk8(acc_out, 8'h10);
    chk8({5'h00, flags_out[2:0]}, 8'h02);
    step(1);
    chk8(acc_out, 8'h00);
    chk8({5'h00, flags_out[2:0]}, 8'h07);
  endtask : t_alu

  task automatic t_rot;
    ld('{13'h1881, 13'h0050, 13'h0610, 13'h06d0, 13'h0410});
    rst(1'b0);
    step(3);
    chk8(acc_out, 8'h40);
    chk1(flags_out[0], 1'b1);
    step(2);
    chk8(acc_out, 8'h03);
    chk1(flags_out[0], 1'b1);
  endtask : t_rot

  task automatic t_jump;
    ld('{13'h1405, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h1809, 13'h0042,
         13'h1811, 13'h0000, 13'h1822});
    rst(1'b0);
    step(1);
    chka(fetch_addr, 11'h005);
    step(1);
    chk8(acc_out, 8'h00);
    step(3);
    chk8(acc_out, 8'h09);
    chka(fetch_addr, 11'h009);
    step(1);
    chk8(acc_out, 8'h22);
  endtask : t_jump

  task automatic t_call;
    ld('{13'h1008, 13'h1833, 13'h100a, 13'h0000, 13'h0000, 13'h0000, 13'h0000,
         13'h0000, 13'h0013, 13'h0000, 13'h1c44});
    rst(1'b0);
    step(2);
    chka(fetch_addr, 11'h008);
    step(2);
    chka(fetch_addr, 11'h001);
    chk1(irq_enable, 1'b1);
    step(1);
    chk8(acc_out, 8'h33);
    step(3);
    chk8(acc_out, 8'h44);
    chka(fetch_addr, 11'h003);
  endtask : t_call

  task automatic t_skip;
    ld('{13'h1801, 13'h0050, 13'h05d0, 13'h1877, 13'h0e10, 13'h0a10, 13'h0e10,
         13'h1899, 13'h0410});
    rst(1'b0);
    step(4);
    chka(fetch_addr, 11'h004);
    chk8(acc_out, 8'h01);
    chk1(flags_out[2], 1'b0);
    step(5);
    chk8(acc_out, 8'h01);
    chka(fetch_addr, 11'h009);
  endtask : t_skip

  task automatic t_spec;
    ld('{13'h185a, 13'h0002, 13'h1800, 13'h0014, 13'h0010, 13'h0011, 13'h0004,
         13'h1e91, 13'h1e81, 13'h140a});
    rom[11'h40a] = 13'h0003;
    rst(1'b0);
    step(2);
    chk8(option_word_reg, 8'h5a);
    step(2);
    chk8(acc_out, 8'h5a);
    step(1);
    chk1(irq_enable, 1'b1);
    step(1);
    chk1(irq_enable, 1'b0);
    step(1);
    chk1(watchdog_clear, 1'b1);
    step(1);
    chk8({6'h00, flags_out[7:6]}, 8'h01);
    step(3);
    chka(fetch_addr, 11'h40a);
    step(1);
    chk1(power_down, 1'b1);
    chk8({6'h00, flags_out[4:3]}, 8'h02);
    repeat (8) @(posedge clk);
    #2;
    chka(fetch_addr, 11'h40b);
    wake_up = 1'b1;
    @(posedge clk);
    #2;
    wake_up = 1'b0;
    chk1(power_down, 1'b0);
  endtask : t_spec

  task automatic t_port;
    ld('{13'h1866, 13'h0005, 13'h0008, 13'h1800, 13'h0015});
    rst(1'b0);
    step(2);
    chk1(port_ctrl_write, 1'b1);
    chk8({4'h0, port_ctrl_index}, 8'h05);
    chk8(port_ctrl_data, 8'h66);
    step(1);
    chk1(port_ctrl_write, 1'b0);
    chk8({4'h0, port_ctrl_index}, 8'h05);
    step(2);
    chk8(acc_out, 8'h66);
  endtask : t_port

  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    cycle_clock_select = 1'b0;
    wake_up = 1'b0;
    foreach (rom[i]) rom[i] = 13'h0000;
    t_timing();
    t_alu();
    t_rot();
    t_jump();
    t_call();
    t_skip();
    t_spec();
    t_port();
    test_done();
  end

endmodule : tb

`default_nettype wire
